// >>> inc/wdt_pkg.sv
// Constants and carrier types of the watchdog and time-base block.
// Assumes a single 50 MHz clock and an AXI4-Lite register master.
package wdt_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CFG  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_INTB = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQM = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CNT  = 8'h14;

  // Configuration register fields
  localparam int unsigned CFG_W        = 17;
  localparam int unsigned CFG_SRC_LSB  = 0;
  localparam int unsigned CFG_WEN      = 2;
  localparam int unsigned CFG_TWO      = 3;
  localparam int unsigned CFG_WSEL_LSB = 4;
  localparam int unsigned CFG_TSEL_LSB = 6;
  localparam int unsigned CFG_LCD_LSB  = 8;
  localparam int unsigned CFG_BUZ_LSB  = 11;
  localparam int unsigned CFG_FAST     = 14;
  localparam int unsigned CFG_RCEN     = 15;
  localparam int unsigned CFG_SYSRC    = 16;
  localparam logic [CFG_W-1:0] CFG_RST = 17'h08004;

  // Status, tick control and interrupt bits
  localparam int unsigned ST_TO    = 0;
  localparam int unsigned ST_PD    = 1;
  localparam int unsigned ST_HALT  = 2;
  localparam int unsigned INTB_TBE = 1;
  localparam int unsigned INTB_TBF = 5;
  localparam int unsigned IRQ_W    = 3;
  localparam int unsigned IRQ_WDT  = 0;
  localparam int unsigned IRQ_TICK = 1;
  localparam int unsigned IRQ_WARM = 2;

  // Divider chain layout and ratios
  localparam int unsigned CHAIN_W  = 15;
  localparam int unsigned WDT_W    = 16;
  localparam int unsigned WDT_EXP0 = 12;
  localparam int unsigned TB_EXP0  = 12;
  localparam logic [2:0]  LCD_MAX  = 3'h6;
  localparam logic [1:0]  INSN_LAST = 2'h3;
  localparam logic [7:0]  TICK_VECTOR = 8'h14;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SRC_RC, SRC_INSN, SRC_RTC} wdt_src_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } wdt_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wdt_axi_rsp_t;

  // One-cycle pulses and the stack-full level from the processor core
  typedef struct packed {
    logic watchdog_clear_op;
    logic watchdog_clear_first;
    logic watchdog_clear_second;
    logic halt_op;
    logic wake;
    logic stack_full;
    logic tick_ack;
  } wdt_core_t;

endpackage

// >>> design/wdt_top.sv
// Watchdog, time base and shared divider chain with AXI4-Lite registers.
// Assumes oscillator and reset pins are asynchronous; core pulses are on clk_in.
`timescale 1ns/100ps
`default_nettype none
module wdt_top
  import wdt_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire wdt_axi_req_t axi_req_in,
  output wdt_axi_rsp_t      axi_rsp_out,
  input  wire wdt_core_t    core_in,
  input  wire logic         rc_osc_in,
  input  wire logic         rtc_osc_in,
  input  wire logic         external_reset_pin_b_in,
  output logic              chip_reset_out,
  output logic              warm_reset_out,
  output logic              tick_req_out,
  output logic [7:0]        tick_vector_out,
  output logic              timeout_flag_out,
  output logic              powerdown_flag_out,
  output logic              sys_osc_stop_out,
  output logic              lcd_clk_out,
  output logic              buzzer_out,
  output logic              clock_out_pin_out,
  output logic              fast_start_bit_out,
  output logic              rc_osc_en_out,
  output logic              irq_out
);

  typedef struct packed {
    logic               rc_s1;
    logic               rc_s2;
    logic               rc_s3;
    logic               rtc_s1;
    logic               rtc_s2;
    logic               rtc_s3;
    logic               res_s1;
    logic               res_s2;
    logic [1:0]         insn_div;
    logic [CHAIN_W-1:0] chain;
    logic [WDT_W-1:0]   wdt;
    logic               first;
    logic               second;
    logic               halted;
    logic               to;
    logic               pd;
    logic               periodic_tick_flag;
    logic               tbe;
    logic [CFG_W-1:0]   cfg;
    logic [IRQ_W-1:0]   irq_s;
    logic [IRQ_W-1:0]   irq_m;
    logic               chip_rst;
    logic               warm_rst;
    logic               clkout;
    logic               cko_en;
    logic               lcd;
    logic               buz;
    logic               aw_got;
    logic [ADDR_W-1:0]  aw_addr;
    logic               w_got;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } wdt_state_t;

  localparam wdt_state_t ST_RST = '{cfg: CFG_RST, res_s1: 1'b1, res_s2: 1'b1, default: '0};

  wdt_state_t s_q;
  wdt_state_t s_d;

  // Byte-lane merge of a write into a 32-bit register image
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Source and chain decode
  wdt_src_t         src;
  logic             rc_edge;
  logic             rtc_edge;
  logic             insn_tick;
  logic             src_tick;
  logic [1:0]       wsel;
  logic [1:0]       tsel;
  logic [2:0]       lsel;
  logic [2:0]       bsel;
  logic [WDT_W-1:0] wdt_limit;
  logic [CHAIN_W-1:0] tb_mask;
  logic             wdt_en;
  logic             ext_res;
  logic             wdt_ovf;
  logic             tb_evt;
  logic             clr_single;
  logic             pair_done;
  logic             do_clear;
  logic             wr_fire;
  logic             rd_fire;
  logic [31:0]      cfg_w;
  logic [31:0]      intb_w;
  logic [31:0]      irqm_w;
  logic [31:0]      rd_val;
  logic             rd_hit;

  // Option fields and source selection
  always_comb begin
    src      = wdt_src_t'(s_q.cfg[CFG_SRC_LSB +: 2]);
    wsel     = s_q.cfg[CFG_WSEL_LSB +: 2];
    tsel     = s_q.cfg[CFG_TSEL_LSB +: 2];
    lsel     = (s_q.cfg[CFG_LCD_LSB +: 3] > LCD_MAX) ? LCD_MAX : s_q.cfg[CFG_LCD_LSB +: 3];
    bsel     = s_q.cfg[CFG_BUZ_LSB +: 3];
    wdt_en   = s_q.cfg[CFG_WEN];
    ext_res  = ~s_q.res_s2;
    rc_edge  = s_q.rc_s2 & ~s_q.rc_s3 & s_q.cfg[CFG_RCEN];
    rtc_edge = s_q.rtc_s2 & ~s_q.rtc_s3;
    insn_tick = (s_q.insn_div == INSN_LAST) & ~s_q.halted;
    case (src)
      SRC_RC:   src_tick = rc_edge;
      SRC_INSN: src_tick = insn_tick;
      SRC_RTC:  src_tick = rtc_edge;
      default:  src_tick = 1'b0;
    endcase
    wdt_limit = WDT_W'((32'h1 << (WDT_EXP0 + 32'(wsel))) - 32'h1);
    tb_mask = CHAIN_W'((32'h1 << (TB_EXP0 + 32'(tsel))) - 32'h1);
    wdt_ovf = wdt_en & src_tick & (s_q.wdt == wdt_limit);
    tb_evt  = src_tick & ((s_q.chain & tb_mask) == tb_mask);
  end

  // Clear scheme decode
  always_comb begin
    clr_single = ~s_q.cfg[CFG_TWO] & core_in.watchdog_clear_op;
    pair_done  = s_q.cfg[CFG_TWO]
               & (s_q.first | core_in.watchdog_clear_first)
               & (s_q.second | core_in.watchdog_clear_second);
    do_clear   = wdt_en & (clr_single | pair_done);
  end

  // Register bus decode
  always_comb begin
    wr_fire = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
    rd_fire = axi_req_in.arvalid & ~s_q.rvalid;
    cfg_w   = merge({{(32-CFG_W){1'b0}}, s_q.cfg}, s_q.wdata, s_q.wstrb);
    intb_w  = merge({26'h0, s_q.periodic_tick_flag, 3'h0, s_q.tbe, 1'b0}, s_q.wdata, s_q.wstrb);
    irqm_w  = merge({29'h0, s_q.irq_m}, s_q.wdata, s_q.wstrb);
    rd_hit  = 1'b1;
    case (axi_req_in.araddr)
      ADDR_CFG:  rd_val = {{(32-CFG_W){1'b0}}, s_q.cfg};
      ADDR_STAT: rd_val = {29'h0, s_q.halted, s_q.pd, s_q.to};
      ADDR_INTB: rd_val = {26'h0, s_q.periodic_tick_flag, 3'h0, s_q.tbe, 1'b0};
      ADDR_IRQS: rd_val = {29'h0, s_q.irq_s};
      ADDR_IRQM: rd_val = {29'h0, s_q.irq_m};
      ADDR_CNT:  rd_val = {s_q.wdt, 1'b0, s_q.chain};
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Pin synchronisers and edge history
    s_d.rc_s1  = rc_osc_in;
    s_d.rc_s2  = s_q.rc_s1;
    s_d.rc_s3  = s_q.rc_s2;
    s_d.rtc_s1 = rtc_osc_in;
    s_d.rtc_s2 = s_q.rtc_s1;
    s_d.rtc_s3 = s_q.rtc_s2;
    s_d.res_s1 = external_reset_pin_b_in;
    s_d.res_s2 = s_q.res_s1;
    s_d.chip_rst = 1'b0;
    s_d.warm_rst = 1'b0;

    // Instruction clock divider, frozen in halt with the system clock
    if (!s_q.halted) begin
      s_d.insn_div = s_q.insn_div + 2'h1;
    end
    // Clock-out enable follows the option only at a phase boundary: no runt pulse
    if (!s_q.halted && (s_q.insn_div == INSN_LAST)) begin
      s_d.cko_en = s_q.cfg[CFG_SYSRC];
    end
    s_d.clkout = s_q.cko_en & s_q.insn_div[1];

    // Shared chain keeps counting in halt on RC or RTC source
    if (src_tick) begin
      s_d.chain = s_q.chain + CHAIN_W'(1);
    end
    s_d.lcd = s_q.chain[{1'b0, lsel} + 4'h1];
    s_d.buz = s_q.chain[{1'b0, bsel} + 4'h1];

    // Watchdog counter
    if (wdt_en && src_tick) begin
      s_d.wdt = s_q.wdt + WDT_W'(1);
    end

    // Clear-pair bookkeeping
    if (wdt_en && s_q.cfg[CFG_TWO]) begin
      if (core_in.watchdog_clear_first) begin
        s_d.first = 1'b1;
      end
      if (core_in.watchdog_clear_second) begin
        s_d.second = 1'b1;
      end
    end

    // Clear by instruction
    if (do_clear) begin
      s_d.wdt    = '0;
      s_d.first  = 1'b0;
      s_d.second = 1'b0;
      s_d.to     = 1'b0;
      s_d.pd     = 1'b0;
    end

    // Halt entry stops system oscillator and restarts the watchdog
    if (core_in.halt_op) begin
      s_d.halted = 1'b1;
      s_d.pd     = 1'b1;
      if (wdt_en) begin
        s_d.wdt = '0;
        s_d.to  = 1'b0;
      end
    end
    if (core_in.wake) begin
      s_d.halted = 1'b0;
    end

    // External reset pin held low
    if (ext_res) begin
      s_d.wdt      = '0;
      s_d.chain    = '0;
      s_d.insn_div = '0;
      s_d.first    = 1'b0;
      s_d.second   = 1'b0;
      s_d.halted   = 1'b0;
    end

    // Overflow wins over any clear in the same cycle
    if (wdt_ovf) begin
      s_d.wdt    = '0;
      s_d.to     = 1'b1;
      s_d.first  = 1'b0;
      s_d.second = 1'b0;
      if (s_q.halted) begin
        s_d.warm_rst = 1'b1;
        s_d.halted   = 1'b0;
      end else begin
        s_d.chip_rst = 1'b1;
      end
    end

    // AXI write address and data, taken in either order
    if (axi_req_in.awvalid && !s_q.aw_got) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req_in.wdata;
      s_d.wstrb = axi_req_in.wstrb;
    end
    if (s_q.bvalid && axi_req_in.bready) begin
      s_d.bvalid = 1'b0;
    end

    // Tick flag cleared by core acknowledge before software and hardware set
    if (core_in.tick_ack) begin
      s_d.periodic_tick_flag = 1'b0;
    end

    // Register write
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      case (s_q.aw_addr)
        ADDR_CFG:  s_d.cfg = cfg_w[CFG_W-1:0];
        ADDR_INTB: begin
          s_d.tbe = intb_w[INTB_TBE];
          s_d.periodic_tick_flag = intb_w[INTB_TBF];
        end
        ADDR_IRQM: s_d.irq_m = irqm_w[IRQ_W-1:0];
        ADDR_STAT, ADDR_IRQS, ADDR_CNT: s_d.bresp = RESP_OKAY;
        default:   s_d.bresp = RESP_SLVERR;
      endcase
    end

    // Register read; an IRQS read clears the sticky interrupt bits
    if (s_q.rvalid && axi_req_in.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_val;
      s_d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      if (axi_req_in.araddr == ADDR_IRQS) begin
        s_d.irq_s = '0;
      end
    end

    // Time-base tick flag; the set wins over any clear
    if (tb_evt) begin
      s_d.periodic_tick_flag = 1'b1;
    end

    // Sticky interrupt events, set after the read clear
    s_d.irq_s[IRQ_WDT]  = s_d.irq_s[IRQ_WDT] | wdt_ovf;
    s_d.irq_s[IRQ_TICK] = s_d.irq_s[IRQ_TICK] | tb_evt;
    s_d.irq_s[IRQ_WARM] = s_d.irq_s[IRQ_WARM] | (wdt_ovf & s_q.halted);
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answers
  always_comb begin
    axi_rsp_out.awready = ~s_q.aw_got;
    axi_rsp_out.wready  = ~s_q.w_got;
    axi_rsp_out.bvalid  = s_q.bvalid;
    axi_rsp_out.bresp   = s_q.bresp;
    axi_rsp_out.arready = ~s_q.rvalid;
    axi_rsp_out.rvalid  = s_q.rvalid;
    axi_rsp_out.rdata   = s_q.rdata;
    axi_rsp_out.rresp   = s_q.rresp;
  end

  // Core-facing and pin outputs
  assign chip_reset_out     = s_q.chip_rst;
  assign warm_reset_out     = s_q.warm_rst;
  assign tick_req_out       = s_q.periodic_tick_flag & s_q.tbe & ~core_in.stack_full;
  assign tick_vector_out    = TICK_VECTOR;
  assign timeout_flag_out   = s_q.to;
  assign powerdown_flag_out = s_q.pd;
  assign sys_osc_stop_out   = s_q.halted;
  assign lcd_clk_out        = s_q.lcd;
  assign buzzer_out         = s_q.buz;
  assign clock_out_pin_out  = s_q.clkout;
  assign fast_start_bit_out = s_q.cfg[CFG_FAST];
  assign rc_osc_en_out      = s_q.cfg[CFG_RCEN];
  assign irq_out            = |(s_q.irq_s & s_q.irq_m);

endmodule
`default_nettype wire

// >>> tb/wdt_core_model.sv
// Core-side model: clear, halt and wake pulses, stack level, tick acknowledge.
// Assumes it shares clk_in with the block; the testbench calls its tasks.
`timescale 1ns/100ps
`default_nettype none
module wdt_core_model
  import wdt_pkg::*;
(
  input  wire logic chip_reset_in,
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic warm_reset_in,
  input  wire logic tick_req_in,
  output wdt_core_t core_out
);
  logic [4:0] op_q;
  logic       full_q;
  logic       ack_q;
  int         chip_cnt;
  int         warm_cnt;
  initial begin
    op_q = '0;
    full_q = 1'b0;
    ack_q = 1'b0;
    chip_cnt = 0;
    warm_cnt = 0;
  end
  assign core_out = {op_q, full_q, ack_q};
  // One-cycle instruction pulse; returns once its effect has landed
  task automatic op(input logic [4:0] p);
    @(posedge clk_in);
    op_q <= p;
    @(posedge clk_in);
    op_q <= '0;
    @(posedge clk_in);
  endtask
  // Stack level seen by the vectoring logic
  task automatic full(input logic f);
    @(posedge clk_in);
    full_q <= f;
  endtask
  // Vectoring takes the tick call; reset pulses are counted
  always @(posedge clk_in) begin
    ack_q <= rst_b_in && tick_req_in && !ack_q;
    chip_cnt <= chip_cnt + int'(chip_reset_in);
    warm_cnt <= warm_cnt + int'(warm_reset_in);
  end
endmodule
`default_nettype wire

// >>> tb/wdt_monitor.sv
// Port checker of the watchdog block.
// Assumes one clock domain; bound to every wdt_top.
`timescale 1ns/100ps
`default_nettype none
module wdt_monitor
  import wdt_pkg::*;
(
  input wire logic         clk_in,
  input wire logic         rst_b_in,
  input wire wdt_axi_req_t axi_req_in,
  input wire wdt_axi_rsp_t axi_rsp_out,
  input wire wdt_core_t    core_in,
  input wire logic         chip_reset_out,
  input wire logic         warm_reset_out,
  input wire logic         tick_req_out,
  input wire logic [7:0]   tick_vector_out,
  input wire logic         timeout_flag_out,
  input wire logic         powerdown_flag_out,
  input wire logic         sys_osc_stop_out,
  input wire logic         clock_out_pin_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Halves of the clock-out wave
  sequence s_hi2; clock_out_pin_out [*2]; endsequence
  sequence s_lo2; !clock_out_pin_out [*2]; endsequence
  property p_vec; tick_vector_out == TICK_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("tick vector wrong");
  property p_full; core_in.stack_full |-> !tick_req_out; endproperty
  a_full: assert property (p_full) else $error("tick call with stack full");
  property p_chip; chip_reset_out |-> timeout_flag_out ##1 !chip_reset_out; endproperty
  a_chip: assert property (p_chip) else $error("chip reset pulse wrong");
  property p_norm; chip_reset_out |-> !$past(sys_osc_stop_out); endproperty
  a_norm: assert property (p_norm) else $error("chip reset while halted");
  property p_warm; warm_reset_out |-> $past(sys_osc_stop_out) && !chip_reset_out; endproperty
  a_warm: assert property (p_warm) else $error("warm reset outside halt");
  property p_to; $rose(timeout_flag_out) |-> chip_reset_out || warm_reset_out; endproperty
  a_to: assert property (p_to) else $error("timeout flag set without overflow");
  property p_halt;
    core_in.halt_op && !core_in.wake |=> sys_osc_stop_out && powerdown_flag_out;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_cko; $rose(clock_out_pin_out) |-> s_hi2 ##1 s_lo2 ##1 clock_out_pin_out; endproperty
  a_cko: assert property (p_cko) else $error("clock out not a quarter rate");
  property p_aw; axi_req_in.awvalid && axi_rsp_out.awready |=> !axi_rsp_out.awready; endproperty
  a_aw: assert property (p_aw) else $error("write address taken twice");
  property p_b;
    axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid && axi_rsp_out.wready
      |-> ##[1:3] axi_rsp_out.bvalid;
  endproperty
  a_b: assert property (p_b) else $error("write response late");
endmodule
bind wdt_top wdt_monitor u_mon (.clk_in, .rst_b_in, .axi_req_in, .axi_rsp_out, .core_in,
  .chip_reset_out, .warm_reset_out, .tick_req_out, .tick_vector_out, .timeout_flag_out,
  .powerdown_flag_out, .sys_osc_stop_out, .clock_out_pin_out);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the watchdog block over AXI4-Lite and core pulses.
// Assumes the core model and bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import wdt_pkg::*;
;
  localparam logic [4:0] CLR = 5'h10, P1 = 5'h08, P2 = 5'h04, HLT = 5'h02, WAK = 5'h01;
  localparam int TPER = 8192; // Period of 2^12 source ticks in clocks
  logic clk_in, rst_b_in, rc_osc, rtc_osc, ext_b, chip_rst, warm_rst, tick_req, to_f, pd_f;
  logic osc_stop, lcd_clk, buz, clk_pin, fast_bit, irq, rcen;
  logic [7:0] vec;
  logic [31:0] d0, d1;
  logic [1:0] rsp;
  wdt_axi_req_t rq;
  wdt_axi_rsp_t rs;
  wdt_core_t core;
  int fail_count, compares, n, c;
  wdt_top dut (.clk_in, .rst_b_in, .axi_req_in(rq), .axi_rsp_out(rs), .core_in(core),
    .rc_osc_in(rc_osc), .rtc_osc_in(rtc_osc), .external_reset_pin_b_in(ext_b),
    .chip_reset_out(chip_rst), .warm_reset_out(warm_rst), .tick_req_out(tick_req),
    .tick_vector_out(vec), .timeout_flag_out(to_f), .powerdown_flag_out(pd_f),
    .sys_osc_stop_out(osc_stop), .lcd_clk_out(lcd_clk), .buzzer_out(buz),
    .clock_out_pin_out(clk_pin), .fast_start_bit_out(fast_bit), .rc_osc_en_out(rcen),
    .irq_out(irq));
  wdt_core_model core_m (.clk_in, .rst_b_in, .chip_reset_in(chip_rst), .warm_reset_in(warm_rst),
    .tick_req_in(tick_req), .core_out(core));
  // Clocks: system, RC source at two clocks a tick, slow real-time source
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    rc_osc = 1'b0;
    #7;
    forever #20 rc_osc = ~rc_osc;
  end
  initial begin
    rtc_osc = 1'b0;
    forever #31 rtc_osc = ~rtc_osc;
  end
  task automatic chk(input logic [31:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic chb(input logic g, e, input string m);
    chk({31'h0, g}, {31'h0, e}, m);
  endtask
  task automatic near(input int g, e, input string m);
    chb((g > e - 8) && (g < e + 8), 1'b1, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge clk_in);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_in);
      if (rs.awready && !aw) begin
        aw = 1'b1;
        rq.awvalid <= 1'b0;
      end
      if (rs.wready && !w) begin
        w = 1'b1;
        rq.wvalid <= 1'b0;
      end
    end
    while (rs.bvalid !== 1'b1) @(posedge clk_in);
    rq.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do @(posedge clk_in); while (rs.arready !== 1'b1);
    rq.arvalid <= 1'b0;
    do @(posedge clk_in); while (rs.rvalid !== 1'b1);
    d = rs.rdata;
    r = rs.rresp;
    rq.rready <= 1'b0;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk_in);
      n++;
    end
  endtask
  task automatic rises(ref logic s, output int r);
    logic p = s;
    r = 0;
    repeat (800) begin
      @(posedge clk_in);
      r += int'(s && !p);
      p = s;
    end
  endtask
  task automatic tdone(input string t);
    $display("test %s finished", t);
  endtask
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    #1600000;
    fail_count++;
    end_sim();
  end
  // Test sequence
  initial begin
    fail_count = 0;
    compares = 0;
    rq = '0;
    ext_b = 1'b1;
    rst_b_in = 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(ADDR_CFG, d0, rsp);
    chk(d0, 32'h0000_8004, "cfg reset");
    chb(rcen, 1'b1, "rc osc enable");
    rd(8'h40, d0, rsp);
    chk({d0[29:0], rsp}, {30'h0, RESP_SLVERR}, "unmapped");
    wr(ADDR_CFG, 32'h0000_C004);
    chb(fast_bit, 1'b1, "fast set");
    wr(ADDR_CFG, 32'h0000_8004);
    chb(fast_bit, 1'b0, "fast clr");
    wr(ADDR_IRQM, 32'h0000_0001);
    chb(irq, 1'b0, "irq idle");
    tdone("registers");
    core_m.op(CLR);
    wait_hi(chip_rst, TPER + 20);
    near(n, TPER, "timeout period");
    chb(to_f, 1'b1, "timeout flag");
    chb(irq, 1'b1, "irq raised");
    rd(ADDR_IRQS, d0, rsp);
    chb(d0[IRQ_WDT], 1'b1, "overflow status");
    repeat (2) @(posedge clk_in);
    chb(irq, 1'b0, "irq cleared");
    tdone("overflow");
    wr(ADDR_CFG, 32'h0000_800C);
    core_m.op(P1);
    repeat (3000) @(posedge clk_in);
    core_m.op(P2);
    chb(to_f, 1'b0, "pair clears flag");
    wait_hi(chip_rst, 4000);
    chb(chip_rst, 1'b0, "pair held off");
    core_m.op(P1);
    wait_hi(chip_rst, TPER);
    near(n, TPER - 4006, "lone first op");
    tdone("pair clear");
    wr(ADDR_CFG, 32'h0000_8004);
    c = core_m.chip_cnt;
    core_m.op(HLT);
    chb(to_f, 1'b0, "halt clears flag");
    chb(pd_f, 1'b1, "halt sets pd");
    chb(osc_stop, 1'b1, "osc stopped");
    wait_hi(warm_rst, TPER + 20);
    near(n, TPER, "halted period");
    chk(32'(core_m.chip_cnt), 32'(c), "no chip reset");
    core_m.op(WAK);
    core_m.op(CLR);
    chb(to_f, 1'b0, "clear op flag");
    chb(pd_f, 1'b0, "clear op pd");
    wr(ADDR_CFG, 32'h0000_8000);
    rd(ADDR_CNT, d0, rsp);
    repeat (100) @(posedge clk_in);
    rd(ADDR_CNT, d1, rsp);
    chk({16'h0, d1[31:16]}, {16'h0, d0[31:16]}, "disabled frozen");
    tdone("halt and disable");
    wr(ADDR_CFG, 32'h0000_8005);
    rd(ADDR_CNT, d0, rsp);
    repeat (8) @(posedge clk_in);
    rd(ADDR_CNT, d1, rsp);
    chb(d1[31:16] !== d0[31:16], 1'b1, "insn clock counts");
    core_m.op(HLT);
    rd(ADDR_CNT, d0, rsp);
    repeat (8) @(posedge clk_in);
    rd(ADDR_CNT, d1, rsp);
    chk({16'h0, d1[31:16]}, {16'h0, d0[31:16]}, "halt stops insn");
    ext_b <= 1'b0;
    repeat (4) @(posedge clk_in);
    ext_b <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(ADDR_STAT, d0, rsp);
    chb(d0[ST_HALT], 1'b0, "pin ends halt");
    rd(ADDR_CNT, d1, rsp);
    chb(d1[31:16] < 16'h0010, 1'b1, "pin clears count");
    tdone("instruction clock");
    wr(ADDR_CFG, 32'h0000_8000);
    wr(ADDR_INTB, 32'h0000_0002);
    wait_hi(tick_req, TPER + 20);
    repeat (4) @(posedge clk_in);
    wait_hi(tick_req, TPER + 20);
    near(n, TPER - 4, "tick period");
    chk({24'h0, vec}, 32'h0000_0014, "vector");
    core_m.full(1'b1);
    repeat (TPER + 20) @(posedge clk_in);
    rd(ADDR_INTB, d0, rsp);
    chb(d0[INTB_TBF], 1'b1, "tick flag bit");
    chb(tick_req, 1'b0, "full blocks call");
    core_m.full(1'b0);
    repeat (4) @(posedge clk_in);
    tdone("time base");
    wr(ADDR_CFG, 32'h0000_8006);
    core_m.op(HLT);
    rd(ADDR_CNT, d0, rsp);
    repeat (40) @(posedge clk_in);
    rd(ADDR_CNT, d1, rsp);
    chb(d1[31:16] !== d0[31:16], 1'b1, "rtc counts in halt");
    core_m.op(WAK);
    tdone("real-time source");
    wr(ADDR_CFG, 32'h0001_8100);
    rises(lcd_clk, n);
    near(n, 50, "lcd divide");
    rises(buz, n);
    near(n, 100, "buzzer divide");
    rises(clk_pin, n);
    near(n, 200, "clock out");
    tdone("dividers");
    end_sim();
  end
endmodule
`default_nettype wire
